// ==== gain_chop_pkg.sv ====
package gain_chop_pkg;

    // ------------------------------------------------------------
    // register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [29:0] GAIN_IDX = 30'h0000_0004;
    localparam logic [29:0] RSVD_IDX = 30'h0000_0005;
    localparam logic [29:0] CHOP_IDX = 30'h0000_0006;
    localparam logic [31:0] GAIN_ADDR = {GAIN_IDX, 2'b00};
    localparam logic [31:0] RSVD_ADDR = {RSVD_IDX, 2'b00};
    localparam logic [31:0] CHOP_ADDR = {CHOP_IDX, 2'b00};

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int CH3_GAIN_LSB = 12;
    localparam int CH2_GAIN_LSB = 8;
    localparam int CH1_GAIN_LSB = 4;
    localparam int CH0_GAIN_LSB = 0;
    localparam int GAIN_CODE_W  = 3;
    localparam int GAIN_FIELD_STEP = 4;
    localparam int CHOP_DELAY_LSB  = 9;
    localparam int CHOP_DELAY_W    = 4;
    localparam int CHOP_ENABLE_BIT = 8;
    localparam int NUM_CH = 4;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic [15:0] GAIN_RESET = 16'h0000;
    localparam logic [15:0] RSVD_RESET = 16'h0000;
    localparam logic [15:0] CHOP_RESET = 16'h0600;
    localparam logic [7:0]  FACTOR_RESET = 8'h01;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] ch3_gain_code;
        logic [2:0] ch2_gain_code;
        logic [2:0] ch1_gain_code;
        logic [2:0] ch0_gain_code;
    } gain_out_t;

    typedef struct packed {
        logic [3:0] chop_delay;
        logic       chop_enable;
    } chop_out_t;

    typedef struct packed {
        logic [15:0]      gain_reg;
        logic [15:0]      rsvd_reg;
        logic [15:0]      chop_reg;
        logic             wr_pend;
        logic [1:0]       wr_sel;
        logic [3:0][7:0]  factor;
        logic [31:0]      hrdata;
        logic             hreadyout;
    } state_t;

endpackage

// ==== adc_gain_chop_config_regs.sv ====
// Contract
// RULE_01 - channel three gain code, bits 14:12, reset zero
// RULE_02 - channel two gain code, bits 10:8, reset zero
// RULE_03 - channel one gain code, bits 6:4, reset zero
// RULE_04 - channel zero bits 2:0; code n means gain 2^n
// RULE_05 - register 05h reserved, resets 0000h, host writes zeros
// RULE_06 - chop register at 06h, resets 0600h, delay upper byte
// RULE_07 - chop register bit 8 enables global chop
// RULE_08 - host writes zero to gain reserved bits
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/10ps
`default_nettype none

module adc_gain_chop_config_regs (
    input  wire logic                     clk_i,
    input  wire logic                     rstn_i,
    input  wire logic                     hsel_i,
    input  wire logic [31:0]              haddr_i,
    input  wire logic [1:0]               htrans_i,
    input  wire logic                     hwrite_i,
    input  wire logic [2:0]               hsize_i,
    input  wire logic [31:0]              hwdata_i,
    input  wire logic                     hready_i,
    output var  logic [31:0]              hrdata_o,
    output var  logic                     hreadyout_o,
    output var  logic                     hresp_o,
    output var  gain_chop_pkg::gain_out_t gain_o,
    output var  logic [3:0][7:0]          gain_factor_o,
    output var  gain_chop_pkg::chop_out_t chop_o
);
    import gain_chop_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    state_t          state_reg;
    state_t          state_next;
    logic            req_valid;
    logic [1:0]      addr_sel;
    logic [15:0]     read_word;
    logic [15:0]     gain_word;
    logic [3:0][2:0] code_next;
    logic [3:0][7:0] factor_next;

    // ------------------------------------------------------------
    // address phase decode
    // ------------------------------------------------------------
    // hsize is not checked: only whole-word transfers are expected
    assign req_valid = hsel_i & htrans_i[1] & hready_i;

    always_comb begin
        if (haddr_i == GAIN_ADDR) begin
            addr_sel = 2'h1;
        end else if (haddr_i == RSVD_ADDR) begin
            addr_sel = 2'h2;
        end else if (haddr_i == CHOP_ADDR) begin
            addr_sel = 2'h3;
        end else begin
            addr_sel = 2'h0;
        end
    end

    // ------------------------------------------------------------
    // per-channel gain factor
    // ------------------------------------------------------------
    // gain word after a pending write, kept apart from state_next
    // so the factor path forms no combinational loop
    always_comb begin
        gain_word = state_reg.gain_reg;
        if (state_reg.wr_pend && state_reg.wr_sel == 2'h1) begin
            gain_word = hwdata_i[15:0];
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < NUM_CH; ch = ch + 1) begin : g_ch
            assign code_next[ch] =
                gain_word[ch*GAIN_FIELD_STEP +: GAIN_CODE_W];
            // one-hot factor: code n gives 2^n, 1 through 128
            assign factor_next[ch] = FACTOR_RESET << code_next[ch]; // RULE_04
        end
    endgenerate

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        state_next = state_reg;
        read_word = 16'h0000;
        state_next.hreadyout = 1'b1;
        // data phase of a pending write lands before any read decode,
        // so a read right behind a write sees the new value
        if (state_reg.wr_pend) begin
            case (state_reg.wr_sel)
                2'h1: begin
                    // reserved bits stored as written; host keeps them zero
                    state_next.gain_reg = hwdata_i[15:0]; // RULE_01 RULE_02 RULE_03 RULE_04 RULE_08
                end
                2'h2: begin
                    state_next.rsvd_reg = hwdata_i[15:0]; // RULE_05
                end
                2'h3: begin
                    state_next.chop_reg = hwdata_i[15:0]; // RULE_06 RULE_07
                end
                default: begin
                    state_next.rsvd_reg = state_reg.rsvd_reg;
                end
            endcase
        end
        state_next.factor = factor_next;
        state_next.wr_pend = req_valid & hwrite_i;
        state_next.wr_sel = addr_sel;
        // read mux, unmapped reads return zero
        case (addr_sel)
            2'h1: begin
                read_word = state_next.gain_reg;
            end
            2'h2: begin
                read_word = state_next.rsvd_reg; // RULE_05
            end
            2'h3: begin
                read_word = state_next.chop_reg;
            end
            default: begin
                read_word = 16'h0000;
            end
        endcase
        if (req_valid && !hwrite_i) begin
            state_next.hrdata = {16'h0000, read_word};
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rstn_i) begin
            state_reg.gain_reg  <= GAIN_RESET; // RULE_01 RULE_02 RULE_03
            state_reg.rsvd_reg  <= RSVD_RESET; // RULE_05
            state_reg.chop_reg  <= CHOP_RESET; // RULE_06 RULE_07
            state_reg.wr_pend   <= 1'b0;
            state_reg.wr_sel    <= 2'h0;
            state_reg.factor    <= {NUM_CH{FACTOR_RESET}};
            state_reg.hrdata    <= 32'h0000_0000;
            state_reg.hreadyout <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // outputs straight from state flops, except hresp_o which is tied low
    // ------------------------------------------------------------
    assign hrdata_o      = state_reg.hrdata;
    assign hreadyout_o   = state_reg.hreadyout;
    // every transfer answers OKAY, unmapped ones included
    assign hresp_o       = 1'b0;
    assign gain_factor_o = state_reg.factor;
    assign gain_o.ch3_gain_code =
        state_reg.gain_reg[CH3_GAIN_LSB +: GAIN_CODE_W]; // RULE_01
    assign gain_o.ch2_gain_code =
        state_reg.gain_reg[CH2_GAIN_LSB +: GAIN_CODE_W]; // RULE_02
    assign gain_o.ch1_gain_code =
        state_reg.gain_reg[CH1_GAIN_LSB +: GAIN_CODE_W]; // RULE_03
    assign gain_o.ch0_gain_code =
        state_reg.gain_reg[CH0_GAIN_LSB +: GAIN_CODE_W]; // RULE_04
    assign chop_o.chop_delay =
        state_reg.chop_reg[CHOP_DELAY_LSB +: CHOP_DELAY_W]; // RULE_06
    assign chop_o.chop_enable =
        state_reg.chop_reg[CHOP_ENABLE_BIT]; // RULE_07

endmodule

`default_nettype wire

// ==== gain_chop_monitor.sv ====
`timescale 1ns/10ps
`default_nettype none
module gain_chop_monitor (
    input wire logic                     clk_i, rstn_i, hsel_i, hwrite_i, hready_i,
    input wire logic [31:0]              haddr_i, hwdata_i, hrdata_o,
    input wire logic [1:0]               htrans_i,
    input wire logic [2:0]               hsize_i,
    input wire logic                     hreadyout_o, hresp_o,
    input wire gain_chop_pkg::gain_out_t gain_o,
    input wire logic [3:0][7:0]          gain_factor_o,
    input wire gain_chop_pkg::chop_out_t chop_o
);
    import gain_chop_pkg::*;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    // data phase word, seen one edge late so it lines up with the update
    logic [31:0] wd_q;
    always_ff @(posedge clk_i) wd_q <= hwdata_i;
    wire logic tk = hsel_i && htrans_i[1] && hready_i;
    wire logic wg = tk && hwrite_i && haddr_i == GAIN_ADDR;
    wire logic wc = tk && hwrite_i && haddr_i == CHOP_ADDR;
    wire logic rr = tk && !hwrite_i && haddr_i == RSVD_ADDR;
    a_ch3_write: assert property (wg |=> ##1 gain_o.ch3_gain_code == wd_q[14:12])
        else $error("ch3 code wrong");
    a_ch2_write: assert property (wg |=> ##1 gain_o.ch2_gain_code == wd_q[10:8])
        else $error("ch2 code wrong");
    a_ch1_write: assert property (wg |=> ##1 gain_o.ch1_gain_code == wd_q[6:4])
        else $error("ch1 code wrong");
    a_ch0_factor: assert property (wg |=> ##1 gain_factor_o[0] == 8'h01 << wd_q[2:0])
        else $error("ch0 factor wrong");
    a_reset_values: assert property ($rose(rstn_i) |-> chop_o == 5'h06 && gain_o == 0)
        else $error("reset values wrong");
    a_rsvd_first: assert property ($rose(rstn_i) && rr |=> hrdata_o == 32'h0)
        else $error("reserved not zero");
    a_chop_delay: assert property (wc |=> ##1 chop_o.chop_delay == wd_q[12:9])
        else $error("chop delay wrong");
    a_chop_enable: assert property (wc |=> ##1 chop_o.chop_enable == wd_q[8])
        else $error("chop enable wrong");
    a_okay_ready: assert property (hresp_o == 1'b0 && hreadyout_o == 1'b1)
        else $error("bus response not okay or not ready");
    a_ch3_factor: assert property (gain_factor_o[3] == 8'h01 << gain_o.ch3_gain_code)
        else $error("ch3 factor wrong");
    a_ch1_factor: assert property (gain_factor_o[1] == 8'h01 << gain_o.ch1_gain_code)
        else $error("ch1 factor wrong");
endmodule
bind adc_gain_chop_config_regs gain_chop_monitor u_gain_chop_monitor (.*);
`default_nettype wire

// ==== test_adc_gain_chop_config_regs.sv ====
`timescale 1ns/10ps
`default_nettype none
module test_adc_gain_chop_config_regs;
    import gain_chop_pkg::*;
    logic            clk_i, rstn_i, hsel_i, hwrite_i;
    logic [31:0]     haddr_i, hwdata_i, hrdata_o, r, v;
    logic [1:0]      htrans_i;
    logic [2:0]      hsize_i;
    wire logic       hready_i, hreadyout_o, hresp_o;
    gain_out_t       gain_o;
    chop_out_t       chop_o;
    logic [3:0][7:0] gain_factor_o;
    logic [11:0]     k;
    logic [31:0]     ad [4];
    logic [31:0]     ex [4];
    int              err_total, checked, seed, i, c;
    adc_gain_chop_config_regs u_adc_gain_chop_config_regs (.*);
    assign hready_i = hreadyout_o;
    initial begin
        clk_i = 1'b0;
        forever #10 clk_i = ~clk_i;
    end
    task end_of_test;
        $display("mismatches %0d compares %0d", err_total, checked);
        if (err_total == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task edge_rdy;
        int n;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (hreadyout_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            err_total++;
            end_of_test;
        end
    endtask
    // whole single word transfer; read data lands in r
    task xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel_i <= 1'b1;
        htrans_i <= 2'h2;
        haddr_i <= a;
        hwrite_i <= w;
        edge_rdy;
        hsel_i <= 1'b0;
        htrans_i <= 2'h0;
        hwdata_i <= d;
        edge_rdy;
        r = hrdata_o;
    endtask
    // reserved gain bits always zero
    function automatic logic [31:0] gw(input logic [11:0] q);
        return {16'h0, 1'b0, q[11:9], 1'b0, q[8:6], 1'b0, q[5:3], 1'b0, q[2:0]};
    endfunction
    initial begin
        seed = 32'hCC90C021;
        {hsel_i, hwrite_i, haddr_i, hwdata_i, htrans_i} = '0;
        hsize_i = 3'h2;
        rstn_i = 1'b0;
        err_total = 0;
        checked = 0;
        ad = '{RSVD_ADDR, GAIN_ADDR, CHOP_ADDR, 32'h0000_001C};
        ex = '{32'h0, 32'h0, 32'h0600, 32'h0};
        repeat (6) @(posedge clk_i);
        rstn_i <= 1'b1;
        for (i = 0; i < 4; i++) begin
            xfer(1'b0, ad[i], 32'h0);
            chk(r, ex[i]);
        end
        chk(chop_o, 32'h06);
        for (i = 0; i < 24; i++) begin
            k = (i < 8) ? {4{i[2:0]}} : 12'($random(seed));
            xfer(1'b1, GAIN_ADDR, gw(k));
            xfer(1'b0, GAIN_ADDR, 32'h0);
            chk(r, gw(k));
            chk(gain_o, k);
            for (c = 0; c < 4; c++) chk(gain_factor_o[c], 8'h01 << k[3*c+:3]);
        end
        for (i = 0; i < 8; i++) begin
            v = $random(seed);
            xfer(1'b1, CHOP_ADDR, {19'h0, v[3:0], i[0], 8'h00});
            xfer(1'b0, CHOP_ADDR, 32'h0);
            chk(r, {19'h0, v[3:0], i[0], 8'h00});
            chk(chop_o, {v[3:0], i[0]});
        end
        xfer(1'b1, RSVD_ADDR, 32'h0);
        xfer(1'b1, 32'h0000_001C, $random(seed));
        xfer(1'b0, RSVD_ADDR, 32'h0);
        chk(r, 32'h0);
        xfer(1'b0, 32'h0000_001C, 32'h0);
        chk(r, 32'h0);
        end_of_test;
    end
endmodule
`default_nettype wire
